/* File: hdl/edh_core.sv */
// Purpose: edh flag handling, anc checksum check, missing packet, counter
// Assumes: crc engines and packet parser sit outside and feed strobes
// Notes: flag port read mode only mirrors the outgoing flags
// Contract
// - valid region: compare embedded crc with calculated crc
// - invalid region: no compare, region edh flag stays zero
// - outgoing eda is incoming eda or incoming edh
// - invalid crc region: fresh crc inserted, outgoing validity high
// - receive: outgoing ues set by incoming ues or low validity
// - receive, missing_packet_flag packet: all three ues flags set
// - outgoing validity high unless host or flag port overrides
// - any anc checksum mismatch in field sets anc edh flag
// - pin or host bit enables anc checksum replacement
// - illegal checksum 3fc to 3ff with correction flags ff and ap edh
// - anc edh override beats checksum verification result
// - bad edh packet checksum sets a readable error flag
// - missing flag set exactly for fields lacking the packet
// - packet counts only with right header at expected position
// - 24 bit counter counts outgoing packets with sensitive errors
// - flag sensitivity active low, checksum sensitivity active high
// - two bit mode: normal, reset, auto reset, hold
// - reset mode clears counter then mode returns to normal
// - auto mode clears counter on read of low counter byte
// - hold mode forces counter to zero until mode changes
// - flag port writes apply to next outgoing packet only
// - flag port writes beat host overrides
// - select 0 ff, 1 ap, 2 anc, 3 in/out and validity
// - first low sample releases pins, later low edges latch data
// - in/out selector resets low and holds last written value
`timescale 1ns/1ps
module edh_core
(
	// clock and reset
	input wire logic REF_CLK_I,
	input wire logic RST_N_I,
	// wishbone slave
	input wire logic [7:0] ADR_I,
	input wire logic [31:0] DAT_I,
	output logic [31:0] DAT_O,
	input wire logic WE_I,
	input wire logic [3:0] SEL_I,
	input wire logic CYC_I,
	input wire logic STB_I,
	output logic ACK_O,
	// video side events
	input wire logic RX_MODE_I,
	input wire logic FIELD_END_I,
	input wire logic [9:0] ANC_WORD_I,
	input wire logic ANC_VLD_I,
	input wire logic EDH_SLOT_I,
	input wire logic PKT_DONE_I,
	input wire logic PKT_CSUM_OK_I,
	input wire logic [14:0] IN_FLAGS_I,
	input wire logic IN_FFV_I,
	input wire logic IN_APV_I,
	input wire logic [15:0] IN_CRC_FF_I,
	input wire logic [15:0] IN_CRC_AP_I,
	input wire logic [15:0] CALC_CRC_FF_I,
	input wire logic [15:0] CALC_CRC_AP_I,
	// anc checksum
	input wire logic ANC_CSUM_DONE_I,
	input wire logic [9:0] ANC_CSUM_RX_I,
	input wire logic [9:0] ANC_CSUM_CALC_I,
	input wire logic ANC_CSUM_CORR_I,
	output logic [9:0] ANC_CSUM_O,
	output logic ANC_CSUM_STB_O,
	// flag port
	input wire logic FL_DIR_I,
	input wire logic [1:0] FL_SEL_I,
	input wire logic [4:0] FL_I,
	output logic [4:0] FL_O,
	output logic FL_OE_N_O,
	// outgoing packet and status
	output logic OUT_STB_O,
	output logic [14:0] OUT_FLAGS_O,
	output logic OUT_FFV_O,
	output logic OUT_APV_O,
	output logic [1:0] CRC_REPL_O,
	output logic MISSING_O,
	output logic CSUM_ERR_O,
	output logic [23:0] ERR_CNT_O
);

////////////////////////////////////////////////////////////////////////////

logic ack_reg;
logic corr_reg;
logic [1:0] mode_reg;
logic [15:0] sens_reg;
logic [16:0] ovr_val_reg;
logic [4:0] ovr_ctrl_reg;
logic [23:0] cnt_reg;
logic [29:0] hdr_sh_reg;
logic pkt_seen_reg;
logic anc_mis_reg;
logic ill_reg;
logic [14:0] in_flags_reg;
logic [1:0] in_v_reg;
logic [1:0] crc_mis_reg;
logic csum_bad_reg;
logic dir_low_d_reg;
logic [2:0][4:0] fp_val_reg;
logic [2:0] fp_pend_reg;
logic [1:0] fp_v_reg;
logic [1:0] fp_v_pend_reg;
logic in_out_reg;

function automatic logic [31:0] merge(input logic [31:0] old);
	merge = old;
	for (int b = 0; b < 4; b++)
	begin
		if (SEL_I[b])
			merge[8*b +: 8] = DAT_I[8*b +: 8];
	end
endfunction

////////////////////////////////////////////////////////////////////////////
// bus decode

wire [5:0] idx = ADR_I[7:2];
wire bus_go = CYC_I && STB_I && !ack_reg;
wire bus_wr = bus_go && WE_I;
wire rd_clr = bus_go && !WE_I && idx == edh_pkg::IDX_CNT_LO;
wire ctrl_wr = bus_wr && idx == edh_pkg::IDX_CTRL && SEL_I[0];
wire [31:0] ctrl_rd = {29'h0, mode_reg, corr_reg};
wire [31:0] status_rd = {29'h0, CSUM_ERR_O, MISSING_O, in_out_reg};
wire [31:0] out_rd = {15'h0, OUT_APV_O, OUT_FFV_O, OUT_FLAGS_O};
wire [31:0] rd_data =
	idx == edh_pkg::IDX_CTRL ? ctrl_rd :
	idx == edh_pkg::IDX_SENS ? {16'h0, sens_reg} :
	idx == edh_pkg::IDX_OVR_VAL ? {15'h0, ovr_val_reg} :
	idx == edh_pkg::IDX_OVR_CTRL ? {27'h0, ovr_ctrl_reg} :
	idx == edh_pkg::IDX_STATUS ? status_rd :
	idx == edh_pkg::IDX_OUT ? out_rd :
	idx == edh_pkg::IDX_CNT_HI ? {16'h0, cnt_reg[23:8]} :
	idx == edh_pkg::IDX_CNT_LO ? {24'h0, cnt_reg[7:0]} :
	32'h0;
// unmapped reads return zero, writes vanish, both still acked
wire [31:0] ctrl_m = merge(ctrl_rd);
wire [31:0] sens_m = merge({16'h0, sens_reg});
wire [31:0] ovr_val_m = merge({15'h0, ovr_val_reg});
wire [31:0] ovr_ctrl_m = merge({27'h0, ovr_ctrl_reg});
wire corr_next = ctrl_wr ? ctrl_m[edh_pkg::CTRL_CORR_BIT] : corr_reg;
wire [1:0] mode_next = ctrl_wr ? ctrl_m[edh_pkg::CTRL_MODE_LSB +: 2] :
	mode_reg == edh_pkg::MODE_RESET ? edh_pkg::MODE_NORMAL :
	mode_reg;

always_ff @(posedge REF_CLK_I or negedge RST_N_I)
begin
	if (!RST_N_I)
	begin
		ack_reg <= 1'b0;
		DAT_O <= 32'h0;
	end
	else
	begin
		ack_reg <= bus_go;
		DAT_O <= bus_go && !WE_I ? rd_data : 32'h0;
	end
end
assign ACK_O = ack_reg;

always_ff @(posedge REF_CLK_I or negedge RST_N_I)
begin
	if (!RST_N_I)
	begin
		corr_reg <= 1'b0;
		mode_reg <= edh_pkg::MODE_NORMAL;
		sens_reg <= edh_pkg::SENS_RST;
		ovr_val_reg <= edh_pkg::OVR_VAL_RST;
		ovr_ctrl_reg <= 5'h00;
	end
	else
	begin
		corr_reg <= corr_next;
		mode_reg <= mode_next;
		if (bus_wr && idx == edh_pkg::IDX_SENS)
			sens_reg <= sens_m[15:0];
		if (bus_wr && idx == edh_pkg::IDX_OVR_VAL)
			ovr_val_reg <= ovr_val_m[16:0];
		if (bus_wr && idx == edh_pkg::IDX_OVR_CTRL)
			ovr_ctrl_reg <= ovr_ctrl_m[4:0];
	end
end

////////////////////////////////////////////////////////////////////////////
// per field capture

// header must complete inside the expected slot to count as a packet
wire hdr_hit = ANC_VLD_I && EDH_SLOT_I && ANC_WORD_I == edh_pkg::HDR_W3
	&& hdr_sh_reg == {edh_pkg::HDR_W0, edh_pkg::HDR_W1, edh_pkg::HDR_W2};
wire corr_en = ANC_CSUM_CORR_I || corr_reg;
wire anc_mis = ANC_CSUM_DONE_I && ANC_CSUM_RX_I != ANC_CSUM_CALC_I;
wire anc_ill = ANC_CSUM_DONE_I && corr_en
	&& ANC_CSUM_RX_I >= edh_pkg::CSUM_ILL_MIN;
// events on the field end edge carry into the next field, never lost
wire pkt_seen_next = hdr_hit || (pkt_seen_reg && !FIELD_END_I);
wire anc_mis_next = anc_mis || (anc_mis_reg && !FIELD_END_I);
wire ill_next = anc_ill || (ill_reg && !FIELD_END_I);
wire [1:0] crc_mis_now = {IN_CRC_AP_I != CALC_CRC_AP_I,
	IN_CRC_FF_I != CALC_CRC_FF_I};

always_ff @(posedge REF_CLK_I or negedge RST_N_I)
begin
	if (!RST_N_I)
	begin
		hdr_sh_reg <= 30'h0;
		pkt_seen_reg <= 1'b0;
		anc_mis_reg <= 1'b0;
		ill_reg <= 1'b0;
	end
	else
	begin
		if (ANC_VLD_I)
			hdr_sh_reg <= {hdr_sh_reg[19:0], ANC_WORD_I};
		pkt_seen_reg <= pkt_seen_next;
		anc_mis_reg <= anc_mis_next;
		ill_reg <= ill_next;
	end
end

always_ff @(posedge REF_CLK_I or negedge RST_N_I)
begin
	if (!RST_N_I)
	begin
		in_flags_reg <= 15'h0;
		in_v_reg <= 2'h3;
		crc_mis_reg <= 2'h0;
		csum_bad_reg <= 1'b0;
	end
	else if (PKT_DONE_I)
	begin
		in_flags_reg <= IN_FLAGS_I;
		in_v_reg <= {IN_APV_I, IN_FFV_I};
		crc_mis_reg <= crc_mis_now;
		csum_bad_reg <= !PKT_CSUM_OK_I;
	end
end

////////////////////////////////////////////////////////////////////////////
// anc checksum replacement

always_ff @(posedge REF_CLK_I or negedge RST_N_I)
begin
	if (!RST_N_I)
	begin
		ANC_CSUM_O <= 10'h0;
		ANC_CSUM_STB_O <= 1'b0;
	end
	else
	begin
		ANC_CSUM_STB_O <= ANC_CSUM_DONE_I;
		if (ANC_CSUM_DONE_I)
			ANC_CSUM_O <= corr_en ? ANC_CSUM_CALC_I : ANC_CSUM_RX_I;
	end
end

////////////////////////////////////////////////////////////////////////////
// flag port

// one idle edge after the release avoids contention on the pins
wire fp_wr = !FL_DIR_I && dir_low_d_reg;
wire fp_misc = fp_wr && FL_SEL_I == edh_pkg::SEL_MISC;
wire [2:0] fp_hit;
wire [2:0] fp_pend_next;
wire [2:0][4:0] base;
wire [2:0][4:0] fin;
wire [2:0] v_w = {1'b1, in_v_reg};
wire [2:0] mis_w = {anc_mis_reg, crc_mis_reg};
wire [2:0][4:0] in_w = in_flags_reg;
wire pkt_rx = RX_MODE_I && pkt_seen_reg;

genvar g;
generate
	for (g = 0; g < 3; g++)
	begin : grp
		assign fp_hit[g] = fp_wr && FL_SEL_I == 2'(g);
		assign fp_pend_next[g] = fp_hit[g]
			|| (fp_pend_reg[g] && !FIELD_END_I);
		// anc checksum check runs whether or not a packet arrived
		assign base[g][edh_pkg::F_EDH] = v_w[g] && mis_w[g]
			&& (g == edh_pkg::GRP_ANC || pkt_rx);
		assign base[g][edh_pkg::F_EDA] = pkt_rx && (in_w[g][edh_pkg::F_EDA]
			|| in_w[g][edh_pkg::F_EDH]);
		assign base[g][edh_pkg::F_IDH] = 1'b0;
		assign base[g][edh_pkg::F_IDA] = pkt_rx && (in_w[g][edh_pkg::F_IDA]
			|| in_w[g][edh_pkg::F_IDH]);
		assign base[g][edh_pkg::F_UES] = RX_MODE_I && (!pkt_seen_reg
			|| in_w[g][edh_pkg::F_UES] || !v_w[g]);
		assign fin[g] = fp_pend_reg[g] ? fp_val_reg[g] :
			ovr_ctrl_reg[g] ? ovr_val_reg[5*g +: 5] : base[g];
	end
endgenerate

always_ff @(posedge REF_CLK_I or negedge RST_N_I)
begin
	if (!RST_N_I)
	begin
		dir_low_d_reg <= 1'b0;
		fp_val_reg <= 15'h0;
		fp_pend_reg <= 3'h0;
		FL_OE_N_O <= 1'b1;
	end
	else
	begin
		dir_low_d_reg <= !FL_DIR_I;
		FL_OE_N_O <= !FL_DIR_I;
		fp_pend_reg <= fp_pend_next;
		for (int k = 0; k < 3; k++)
		begin
			if (fp_hit[k])
				fp_val_reg[k] <= FL_I;
		end
	end
end

always_ff @(posedge REF_CLK_I or negedge RST_N_I)
begin
	if (!RST_N_I)
	begin
		fp_v_reg <= 2'h3;
		fp_v_pend_reg <= 2'h0;
		in_out_reg <= 1'b0;
	end
	else
	begin
		fp_v_pend_reg <= fp_misc ? 2'h3 : FIELD_END_I ? 2'h0 : fp_v_pend_reg;
		if (fp_misc)
		begin
			fp_v_reg <= FL_I[3:2];
			in_out_reg <= FL_I[4];
		end
	end
end

// read mode only mirrors outgoing flags; incoming view not offered
wire [4:0] misc_rd = {CSUM_ERR_O, OUT_APV_O, OUT_FFV_O, 2'h0};
wire [4:0] fl_next = FL_SEL_I == edh_pkg::SEL_MISC ? misc_rd :
	OUT_FLAGS_O[5*FL_SEL_I +: 5];

always_ff @(posedge REF_CLK_I or negedge RST_N_I)
begin
	if (!RST_N_I)
		FL_O <= 5'h0;
	else
		FL_O <= fl_next;
end

////////////////////////////////////////////////////////////////////////////
// outgoing packet

// illegal anc checksum leaves ff and ap edh set even under overrides
wire [14:0] out_next = fin | {5'h0, 4'h0, ill_reg, 4'h0, ill_reg};
wire ffv_next = fp_v_pend_reg[0] ? fp_v_reg[0] :
	ovr_ctrl_reg[edh_pkg::OVR_CTRL_FFV_BIT] ?
	ovr_val_reg[edh_pkg::OVR_FFV_BIT] : 1'b1;
wire apv_next = fp_v_pend_reg[1] ? fp_v_reg[1] :
	ovr_ctrl_reg[edh_pkg::OVR_CTRL_APV_BIT] ?
	ovr_val_reg[edh_pkg::OVR_APV_BIT] : 1'b1;
wire csum_now = pkt_seen_reg && csum_bad_reg;
wire cnt_hit = FIELD_END_I && (|(out_next & ~sens_reg[14:0])
	|| (csum_now && sens_reg[edh_pkg::SENS_CSUM_BIT]));
wire [23:0] cnt_inc = cnt_reg + {23'h0, cnt_hit};
wire cnt_zero = mode_reg == edh_pkg::MODE_HOLD
	|| mode_reg == edh_pkg::MODE_RESET;
wire [23:0] cnt_next = cnt_zero ? edh_pkg::CNT_RST :
	mode_reg == edh_pkg::MODE_AUTO && rd_clr ? {23'h0, cnt_hit} :
	cnt_inc;

always_ff @(posedge REF_CLK_I or negedge RST_N_I)
begin
	if (!RST_N_I)
		cnt_reg <= edh_pkg::CNT_RST;
	else
		cnt_reg <= cnt_next;
end
assign ERR_CNT_O = cnt_reg;

always_ff @(posedge REF_CLK_I or negedge RST_N_I)
begin
	if (!RST_N_I)
	begin
		OUT_STB_O <= 1'b0;
		OUT_FLAGS_O <= 15'h0;
		OUT_FFV_O <= 1'b1;
		OUT_APV_O <= 1'b1;
		CRC_REPL_O <= 2'h0;
		MISSING_O <= 1'b0;
		CSUM_ERR_O <= 1'b0;
	end
	else
	begin
		OUT_STB_O <= FIELD_END_I;
		if (FIELD_END_I)
		begin
			OUT_FLAGS_O <= out_next;
			OUT_FFV_O <= ffv_next;
			OUT_APV_O <= apv_next;
			CRC_REPL_O <= pkt_seen_reg ? ~in_v_reg : 2'h0;
			MISSING_O <= !pkt_seen_reg;
			CSUM_ERR_O <= csum_now;
		end
	end
end

////////////////////////////////////////////////////////////////////////////
// checks

default clocking cb @(posedge REF_CLK_I); endclocking
default disable iff (!RST_N_I);

cnt_step_a: assert property (cnt_hit && mode_reg == edh_pkg::MODE_NORMAL
	|=> cnt_reg == $past(cnt_reg) + 24'h1)
	else $error("counter did not step by one");
hold_zero_a: assert property (mode_reg == edh_pkg::MODE_HOLD
	|=> cnt_reg == 24'h0)
	else $error("counter not held at zero");
mode_back_a: assert property (mode_reg == edh_pkg::MODE_RESET && !ctrl_wr
	|=> mode_reg == edh_pkg::MODE_NORMAL && cnt_reg == 24'h0)
	else $error("reset mode did not clear and return");
missing_a: assert property (FIELD_END_I
	|=> MISSING_O == !$past(pkt_seen_reg) && OUT_STB_O)
	else $error("missing flag wrong");
ues_all_a: assert property (FIELD_END_I && RX_MODE_I && !pkt_seen_reg
	&& fp_pend_reg == 3'h0 && ovr_ctrl_reg[2:0] == 3'h0
	|=> OUT_FLAGS_O[14] && OUT_FLAGS_O[9] && OUT_FLAGS_O[4])
	else $error("ues flags not set for missing packet");
inv_crc_a: assert property (pkt_rx && !in_v_reg[0]
	|-> !base[0][edh_pkg::F_EDH] && base[0][edh_pkg::F_UES])
	else $error("invalid region flags wrong");
fp_prio_a: assert property (FIELD_END_I && fp_pend_reg[2]
	|=> OUT_FLAGS_O[14:10] == $past(fp_val_reg[2]))
	else $error("flag port value not applied");
fp_once_a: assert property (FIELD_END_I && !fp_wr
	|=> fp_pend_reg == 3'h0)
	else $error("flag port write outlived one packet");
csum_fix_a: assert property (ANC_CSUM_DONE_I && corr_en
	|=> ANC_CSUM_STB_O && ANC_CSUM_O == $past(ANC_CSUM_CALC_I))
	else $error("anc checksum not replaced");
pin_off_a: assert property ($fell(FL_DIR_I) |=> FL_OE_N_O [*2])
	else $error("flag pins still driven");

pkt_field_c: cover property (hdr_hit ##[1:1000] FIELD_END_I);
fp_write_c: cover property (fp_wr ##1 fp_wr ##1 fp_wr);
auto_clr_c: cover property (rd_clr && mode_reg == edh_pkg::MODE_AUTO);
reset_mode_c: cover property (mode_reg == edh_pkg::MODE_RESET);

endmodule

/* File: hdl/edh_pkg.sv */
// Purpose: shared constants for the edh flag processing core
// Assumes: register index times four gives the wishbone byte address
// Notes: flag groups are five bits, ues ida idh eda edh from msb down
package edh_pkg;
	// register indices
	localparam logic [5:0] IDX_CTRL = 6'h00;
	localparam logic [5:0] IDX_SENS = 6'h01;
	localparam logic [5:0] IDX_OVR_VAL = 6'h02;
	localparam logic [5:0] IDX_OVR_CTRL = 6'h03;
	localparam logic [5:0] IDX_STATUS = 6'h04;
	localparam logic [5:0] IDX_OUT = 6'h05;
	localparam logic [5:0] IDX_CNT_HI = 6'h10;
	localparam logic [5:0] IDX_CNT_LO = 6'h11;
	// field positions
	localparam int CTRL_CORR_BIT = 0;
	localparam int CTRL_MODE_LSB = 1;
	localparam int OVR_FFV_BIT = 15;
	localparam int OVR_APV_BIT = 16;
	localparam int OVR_CTRL_FFV_BIT = 3;
	localparam int OVR_CTRL_APV_BIT = 4;
	localparam int SENS_CSUM_BIT = 15;
	localparam int F_EDH = 0;
	localparam int F_EDA = 1;
	localparam int F_IDH = 2;
	localparam int F_IDA = 3;
	localparam int F_UES = 4;
	localparam int GRP_ANC = 2;
	// reset values
	localparam logic [15:0] SENS_RST = 16'h7fff;
	localparam logic [16:0] OVR_VAL_RST = 17'h18000;
	localparam logic [23:0] CNT_RST = 24'h000000;
	// counter modes
	localparam logic [1:0] MODE_NORMAL = 2'h0;
	localparam logic [1:0] MODE_RESET = 2'h1;
	localparam logic [1:0] MODE_AUTO = 2'h2;
	localparam logic [1:0] MODE_HOLD = 2'h3;
	// flag port selects
	localparam logic [1:0] SEL_MISC = 2'h3;
	// edh packet header words and lowest illegal anc checksum
	localparam logic [9:0] HDR_W0 = 10'h000;
	localparam logic [9:0] HDR_W1 = 10'h3ff;
	localparam logic [9:0] HDR_W2 = 10'h3ff;
	localparam logic [9:0] HDR_W3 = 10'h1f4;
	localparam logic [9:0] CSUM_ILL_MIN = 10'h3fc;
endpackage

/* File: tb/flag_ctrl.sv */
// Purpose: external controller that writes the synchronous flag port
// Assumes: one select and one flag word per go pulse
// Notes: the bench resolves the shared flag pins from both enables
`timescale 1ns/1ps
module flag_ctrl
(
	// clock
	input wire logic clk_i,
	// command from the bench
	input wire logic go_i,
	input wire logic [1:0] wsel_i,
	input wire logic [4:0] wdata_i,
	output logic busy_o,
	// flag port
	output logic dir_o,
	output logic [1:0] sel_o,
	output logic [4:0] fl_o,
	output logic drive_o
);
	logic [1:0] step_reg;
	////////////////////////////////////////////////////////////////
	assign busy_o = go_i || (step_reg != 2'h0);
	initial
	begin
		step_reg = 2'h0;
		dir_o = 1'b1;
		sel_o = 2'h0;
		fl_o = 5'h00;
		drive_o = 1'b0;
	end
	always @(posedge clk_i)
	begin
		case (step_reg)
			2'h0:
				if (go_i)
				begin
					dir_o <= 1'b0;
					sel_o <= wsel_i;
					step_reg <= 2'h1;
				end
			2'h1:
			begin
				// one idle clock first, so the pins are never fought over
				fl_o <= wdata_i;
				drive_o <= 1'b1;
				step_reg <= 2'h2;
			end
			default:
			begin
				dir_o <= 1'b1;
				drive_o <= 1'b0;
				step_reg <= 2'h0;
			end
		endcase
	end
endmodule

/* File: tb/testbench.sv */
// Purpose: self checking bench for the edh core
// Assumes: flag port driven by the controller model
// Notes: one field in transmit mode, the rest in receive mode
`timescale 1ns/1ps
module testbench;
	logic REF_CLK_I, RST_N_I, WE_I, CYC_I, STB_I, ACK_O, RX_MODE_I;
	logic FIELD_END_I, ANC_VLD_I, EDH_SLOT_I, PKT_DONE_I, PKT_CSUM_OK_I;
	logic IN_FFV_I, IN_APV_I, ANC_CSUM_DONE_I, ANC_CSUM_CORR_I;
	logic ANC_CSUM_STB_O, FL_DIR_I, FL_OE_N_O, OUT_STB_O, OUT_FFV_O;
	logic OUT_APV_O, MISSING_O, CSUM_ERR_O, go, busy, ctl_drv;
	logic [7:0] ADR_I;
	logic [31:0] DAT_I, DAT_O, rdat;
	logic [3:0] SEL_I;
	logic [9:0] ANC_WORD_I, ANC_CSUM_RX_I, ANC_CSUM_CALC_I, ANC_CSUM_O;
	logic [14:0] IN_FLAGS_I, OUT_FLAGS_O;
	logic [15:0] IN_CRC_FF_I, IN_CRC_AP_I, CALC_CRC_FF_I, CALC_CRC_AP_I;
	logic [1:0] FL_SEL_I, CRC_REPL_O, wsel;
	logic [4:0] FL_I, FL_O, wdata, ctl_fl;
	logic [23:0] ERR_CNT_O;
	logic [9:0] hw [4] = '{10'h000, 10'h3ff, 10'h3ff, 10'h1f4};
	int err_count, tests_run, cycles;
	////////////////////////////////////////////////////////////////
	// a released pin shows the inverse of its last drive
	assign FL_I = !FL_OE_N_O ? FL_O : (ctl_drv ? ctl_fl : ~ctl_fl);
	edh_core dut (.*);
	flag_ctrl ctl (.clk_i(REF_CLK_I), .go_i(go), .wsel_i(wsel),
		.wdata_i(wdata), .busy_o(busy), .dir_o(FL_DIR_I),
		.sel_o(FL_SEL_I), .fl_o(ctl_fl), .drive_o(ctl_drv));
	initial
	begin
		REF_CLK_I = 1'b0;
		forever #20 REF_CLK_I = ~REF_CLK_I;
	end
	// the run needs under a thousand cycles
	always @(posedge REF_CLK_I)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			err_count++;
			report_and_stop();
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			err_count++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [5:0] idx,
		input logic [31:0] d);
		@(posedge REF_CLK_I);
		CYC_I <= 1'b1;
		STB_I <= 1'b1;
		WE_I <= w;
		ADR_I <= {idx, 2'b00};
		DAT_I <= d;
		@(posedge REF_CLK_I);
		while (ACK_O !== 1'b1)
			@(posedge REF_CLK_I);
		rdat = DAT_O;
		CYC_I <= 1'b0;
		STB_I <= 1'b0;
	endtask
	// how: bit0 header sent, bit1 header at the expected slot
	task automatic field(input logic [1:0] how);
		for (int i = 0; i < 4 && how[0]; i++)
		begin
			@(posedge REF_CLK_I);
			ANC_VLD_I <= 1'b1;
			ANC_WORD_I <= hw[i];
			EDH_SLOT_I <= how[1] && i == 3;
		end
		@(posedge REF_CLK_I);
		ANC_VLD_I <= 1'b0;
		EDH_SLOT_I <= 1'b0;
		PKT_DONE_I <= &how;
		@(posedge REF_CLK_I);
		PKT_DONE_I <= 1'b0;
		FIELD_END_I <= 1'b1;
		@(posedge REF_CLK_I);
		FIELD_END_I <= 1'b0;
		while (OUT_STB_O !== 1'b1)
			@(posedge REF_CLK_I);
	endtask
	task automatic anc(input logic [9:0] rx, input logic [9:0] calc);
		@(posedge REF_CLK_I);
		ANC_CSUM_DONE_I <= 1'b1;
		ANC_CSUM_RX_I <= rx;
		ANC_CSUM_CALC_I <= calc;
		@(posedge REF_CLK_I);
		ANC_CSUM_DONE_I <= 1'b0;
		while (ANC_CSUM_STB_O !== 1'b1)
			@(posedge REF_CLK_I);
	endtask
	task automatic fp_write(input logic [1:0] s, input logic [4:0] d);
		@(posedge REF_CLK_I);
		go <= 1'b1;
		wsel <= s;
		wdata <= d;
		@(posedge REF_CLK_I);
		go <= 1'b0;
		repeat (2) @(posedge REF_CLK_I);
		check(32'(FL_OE_N_O), 32'h1);
		while (busy)
			@(posedge REF_CLK_I);
	endtask
	task automatic dflt();
		IN_FLAGS_I <= 15'h0000;
		{IN_FFV_I, IN_APV_I, PKT_CSUM_OK_I} <= 3'h7;
		{IN_CRC_FF_I, IN_CRC_AP_I} <= 32'h5a5ac3c3;
		{CALC_CRC_FF_I, CALC_CRC_AP_I} <= 32'h5a5ac3c3;
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		{RST_N_I, WE_I, CYC_I, STB_I, FIELD_END_I, ANC_VLD_I} = '0;
		{EDH_SLOT_I, PKT_DONE_I, ANC_CSUM_DONE_I, ANC_CSUM_CORR_I, go} = '0;
		{ADR_I, DAT_I, ANC_WORD_I, ANC_CSUM_RX_I, ANC_CSUM_CALC_I} = '0;
		{wsel, wdata} = '0;
		SEL_I = 4'hf;
		RX_MODE_I = 1'b1;
		dflt();
		repeat (5) @(posedge REF_CLK_I);
		RST_N_I <= 1'b1;
		wb(1'b0, edh_pkg::IDX_SENS, 32'h0);
		check(rdat, 32'h00007fff);
		wb(1'b0, edh_pkg::IDX_OVR_VAL, 32'h0);
		check(rdat, 32'h00018000);
		wb(1'b0, edh_pkg::IDX_STATUS, 32'h0);
		check(rdat, 32'h0);
		wb(1'b0, 6'h3f, 32'h0);
		check(rdat, 32'h0);
		check(32'(FL_OE_N_O), 32'h0);
		field(2'b00);
		check(32'(MISSING_O), 32'h1);
		check(32'(OUT_FLAGS_O), 32'h4210);
		check(32'(ERR_CNT_O), 32'h0);
		field(2'b01);
		check(32'(MISSING_O), 32'h1);
		RX_MODE_I <= 1'b0;
		field(2'b00);
		check(32'(OUT_FLAGS_O), 32'h0);
		check(32'(MISSING_O), 32'h1);
		RX_MODE_I <= 1'b1;
		field(2'b11);
		check(32'(MISSING_O), 32'h0);
		check(32'(OUT_FLAGS_O), 32'h0);
		// invalid ff crc, bad ap crc and a bad packet checksum at once
		wb(1'b1, edh_pkg::IDX_SENS, 32'h0000ffff);
		IN_FFV_I <= 1'b0;
		IN_FLAGS_I <= 15'h4001;
		{CALC_CRC_FF_I, CALC_CRC_AP_I} <= 32'h0bad0bad;
		PKT_CSUM_OK_I <= 1'b0;
		field(2'b11);
		check(32'(OUT_FLAGS_O), 32'h4032);
		check(32'(CRC_REPL_O), 32'h1);
		check(32'(OUT_FFV_O), 32'h1);
		check(32'(CSUM_ERR_O), 32'h1);
		check(32'(ERR_CNT_O), 32'h1);
		dflt();
		anc(10'h101, 10'h102);
		check(32'(ANC_CSUM_O), 32'h101);
		field(2'b11);
		check(32'(OUT_FLAGS_O), 32'h0400);
		ANC_CSUM_CORR_I <= 1'b1;
		anc(10'h3fd, 10'h3fc);
		check(32'(ANC_CSUM_O), 32'h3fc);
		field(2'b11);
		check(32'(OUT_FLAGS_O), 32'h0421);
		ANC_CSUM_CORR_I <= 1'b0;
		wb(1'b1, edh_pkg::IDX_CTRL, 32'h1);
		anc(10'h105, 10'h106);
		check(32'(ANC_CSUM_O), 32'h106);
		wb(1'b1, edh_pkg::IDX_CTRL, 32'h0);
		// host overrides anc, the port overrides all groups once
		wb(1'b1, edh_pkg::IDX_OVR_VAL, 32'h0001d400);
		wb(1'b1, edh_pkg::IDX_OVR_CTRL, 32'h4);
		fp_write(2'h0, 5'h03);
		fp_write(2'h1, 5'h0c);
		fp_write(2'h2, 5'h0a);
		field(2'b11);
		check(32'(OUT_FLAGS_O), 32'h2983);
		field(2'b11);
		check(32'(OUT_FLAGS_O), 32'h5400);
		wb(1'b1, edh_pkg::IDX_OVR_CTRL, 32'h0);
		fp_write(2'h3, 5'h10);
		field(2'b11);
		check(32'({OUT_APV_O, OUT_FFV_O}), 32'h0);
		field(2'b11);
		check(32'({OUT_APV_O, OUT_FFV_O}), 32'h3);
		wb(1'b0, edh_pkg::IDX_STATUS, 32'h0);
		check(rdat, 32'h1);
		check(32'(FL_O), 32'h0c);
		// counter modes
		wb(1'b1, edh_pkg::IDX_SENS, 32'h0);
		field(2'b00);
		check(32'(ERR_CNT_O), 32'h2);
		wb(1'b0, edh_pkg::IDX_CNT_LO, 32'h0);
		check(rdat, 32'h2);
		check(32'(ERR_CNT_O), 32'h2);
		wb(1'b1, edh_pkg::IDX_CTRL, 32'h4);
		wb(1'b0, edh_pkg::IDX_CNT_LO, 32'h0);
		check(rdat, 32'h2);
		check(32'(ERR_CNT_O), 32'h0);
		field(2'b00);
		wb(1'b1, edh_pkg::IDX_CTRL, 32'h2);
		wb(1'b0, edh_pkg::IDX_CTRL, 32'h0);
		check(rdat, 32'h0);
		check(32'(ERR_CNT_O), 32'h0);
		field(2'b00);
		check(32'(ERR_CNT_O), 32'h1);
		wb(1'b1, edh_pkg::IDX_CTRL, 32'h6);
		field(2'b00);
		check(32'(ERR_CNT_O), 32'h0);
		wb(1'b1, edh_pkg::IDX_CTRL, 32'h0);
		field(2'b00);
		check(32'(ERR_CNT_O), 32'h1);
		wb(1'b0, edh_pkg::IDX_CNT_HI, 32'h0);
		check(rdat, 32'h0);
		report_and_stop();
	end
endmodule
